//--- src/dlt_top.sv
`timescale 1ns/1ps
module dlt_top
  import dlt_pkg::*;
#(
  parameter int VW = DLT_VAL_W,
  parameter int PW = DLT_PULSE_W,
  parameter logic [PW-1:0] PULSE_RST = DLT_PULSE_RST
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Measurement stream
  input wire logic [VW-1:0] reading,
  input wire logic reading_valid,
  input wire logic instr_idle,
  input wire logic local_limits_off,
  // Indicators
  output dlt_indic_t indic,
  output dlt_hit_t event_one,
  output dlt_hit_t event_two,
  // Handler outputs
  output logic [4:0] dig_out,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [VW-1:0] upper_bound_pair_one_ff, lower_bound_pair_one_ff;
  logic [VW-1:0] upper_bound_pair_two_ff, lower_bound_pair_two_ff;
  logic [11:0] upper_hi_ff;
  logic [7:0] ctrl_ff;
  logic [PW-1:0] pulse_ff;
  logic fail_one_ff, fail_two_ff;
  dlt_hit_t hit_one_ff, hit_two_ff;
  logic master_ff;
  logic [DLT_IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [31:0] rdata_ff;
  logic idle_s1_ff, idle_s2_ff, loc_s1_ff, loc_s2_ff;
  dlt_hit_t nxt_one, nxt_two;
  logic en_one, en_two;
  logic wr_ctrl, wr_cmd;
  logic [4:0] raw_out;
  logic [4:0] act_out;

  // Reading reaches or passes either bound
  function automatic dlt_hit_t cmp(input logic [VW-1:0] r, input logic [VW-1:0] hi,
                                   input logic [VW-1:0] lo);
    dlt_hit_t h;
    h.high = $signed(r) >= $signed(hi);
    h.low = $signed(r) <= $signed(lo);
    return h;
  endfunction

  // Write value with upper word bits from the staging register
  function automatic logic [VW-1:0] wide(input logic [31:0] lo, input logic [11:0] hi);
    return VW'({hi, lo});
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
      loc_s1_ff <= 1'b0;
      loc_s2_ff <= 1'b0;
    end
    else if (ce)
    begin
      idle_s1_ff <= instr_idle;
      idle_s2_ff <= idle_s1_ff;
      loc_s1_ff <= local_limits_off;
      loc_s2_ff <= loc_s1_ff;
    end
  end

  assign en_one = ctrl_ff[DLT_CTRL_EN_ONE] && !loc_s2_ff;
  assign en_two = ctrl_ff[DLT_CTRL_EN_TWO] && !loc_s2_ff;
  assign wr_ctrl = reg_wr && (reg_addr == DLT_ADR_CTRL);
  assign wr_cmd = reg_wr && (reg_addr == DLT_ADR_CMD);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      upper_bound_pair_one_ff <= '0;
      lower_bound_pair_one_ff <= '0;
      upper_bound_pair_two_ff <= '0;
      lower_bound_pair_two_ff <= '0;
      upper_hi_ff <= 12'h000;
      ctrl_ff <= DLT_CTRL_RST;
      pulse_ff <= PULSE_RST;
      irq_mask_ff <= '0;
    end
    else if (ce && reg_wr)
    begin
      unique case (reg_addr)
        DLT_ADR_UPPER_HI: upper_hi_ff <= reg_wdata[11:0];
        DLT_ADR_UPPER_ONE: upper_bound_pair_one_ff <= wide(reg_wdata, upper_hi_ff);
        DLT_ADR_LOWER_ONE: lower_bound_pair_one_ff <= wide(reg_wdata, upper_hi_ff);
        DLT_ADR_UPPER_TWO: upper_bound_pair_two_ff <= wide(reg_wdata, upper_hi_ff);
        DLT_ADR_LOWER_TWO: lower_bound_pair_two_ff <= wide(reg_wdata, upper_hi_ff);
        DLT_ADR_CTRL: ctrl_ff <= reg_wdata[7:0];
        DLT_ADR_PULSE:
        begin
          if ({upper_hi_ff, reg_wdata} < 44'(DLT_PULSE_MIN))
            pulse_ff <= DLT_PULSE_MIN;
          else if ({upper_hi_ff, reg_wdata} > 44'(DLT_PULSE_MAX))
            pulse_ff <= DLT_PULSE_MAX;
          else
            pulse_ff <= PW'({upper_hi_ff, reg_wdata});
        end
        DLT_ADR_IRQ_MASK: irq_mask_ff <= reg_wdata[DLT_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Comparison and fail flags
  // ****************************************************************
  always_comb
  begin
    nxt_one = cmp(reading, upper_bound_pair_one_ff, lower_bound_pair_one_ff);
    nxt_two = cmp(reading, upper_bound_pair_two_ff, lower_bound_pair_two_ff);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hit_one_ff <= '0;
      hit_two_ff <= '0;
    end
    else if (ce && reading_valid)
    begin
      hit_one_ff <= en_one ? nxt_one : '0;
      hit_two_ff <= en_two ? nxt_two : '0;
    end
  end

  // Fail one; a new failing reading wins over any clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fail_one_ff <= 1'b0;
    else if (ce)
    begin
      if (reading_valid && en_one && (nxt_one.high || nxt_one.low))
        fail_one_ff <= 1'b1;
      else if (wr_cmd && reg_wdata[DLT_CMD_CLR_ONE])
        fail_one_ff <= 1'b0;
      else if (ctrl_ff[DLT_CTRL_AUTO_ONE] && idle_s2_ff)
        fail_one_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fail_two_ff <= 1'b0;
    else if (ce)
    begin
      if (reading_valid && en_two && (nxt_two.high || nxt_two.low))
        fail_two_ff <= 1'b1;
      else if (wr_cmd && reg_wdata[DLT_CMD_CLR_TWO])
        fail_two_ff <= 1'b0;
      else if (ctrl_ff[DLT_CTRL_AUTO_TWO] && idle_s2_ff)
        fail_two_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Master latch
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      master_ff <= 1'b0;
    else if (ce)
    begin
      if (ctrl_ff[DLT_CTRL_LATCH] && (|raw_out[3:0]))
        master_ff <= 1'b1;
      else if ((wr_cmd && reg_wdata[DLT_CMD_CLR_MASTER]) || !ctrl_ff[DLT_CTRL_LATCH])
        master_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Handler outputs
  // ****************************************************************
  always_comb
  begin
    raw_out[0] = hit_one_ff.low;
    raw_out[1] = hit_one_ff.high;
    raw_out[2] = hit_two_ff.low;
    raw_out[3] = hit_two_ff.high;
    raw_out[4] = hit_one_ff.high || hit_one_ff.low || hit_two_ff.high || hit_two_ff.low
                 || master_ff;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_pulse
      dlt_pulse #(.W(PW)) u_pulse (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .pulse_en(ctrl_ff[DLT_CTRL_PULSE_EN]),
        .width(pulse_ff),
        .level(raw_out[gi] && ctrl_ff[DLT_CTRL_OUT_EN]),
        .active(act_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      dig_out <= 5'h00;
    else if (ce)
      // Enable gate also cuts a pulse already running when outputs turn off
      dig_out <= {5{ctrl_ff[DLT_CTRL_SENSE_LOW]}}
                 ^ (act_out & {5{ctrl_ff[DLT_CTRL_OUT_EN]}});
  end

  // ****************************************************************
  // Indicators and event bits
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      indic <= '0;
    else if (ce)
    begin
      indic <= '0;
      if (en_one)
      begin
        indic.ind_high <= hit_one_ff.high;
        indic.ind_low <= hit_one_ff.low;
        indic.ind_in <= !(hit_one_ff.high || hit_one_ff.low);
      end
      else if (en_two)
      begin
        indic.ind_high <= hit_two_ff.high;
        indic.ind_low <= hit_two_ff.low;
        indic.inside_window_two_msg <= !(hit_two_ff.high || hit_two_ff.low);
        indic.digit_two <= hit_two_ff.high || hit_two_ff.low;
      end
    end
  end

  assign event_one = hit_one_ff;
  assign event_two = hit_two_ff;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irq_stat_ff <= '0;
    else if (ce)
    begin
      for (int i = 0; i < DLT_IRQ_W; i++)
      begin
        if ((i == DLT_IRQ_FAIL_ONE ? nxt_one.high || nxt_one.low : nxt_two.high || nxt_two.low)
            && reading_valid && (i == DLT_IRQ_FAIL_ONE ? en_one : en_two))
          irq_stat_ff[i] <= 1'b1;
        else if (reg_wr && reg_addr == DLT_ADR_IRQ_STAT && reg_wdata[i])
          irq_stat_ff[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 32'h0000_0000;
    else if (ce)
    begin
      rdata_ff <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          DLT_ADR_UPPER_ONE: rdata_ff <= upper_bound_pair_one_ff[31:0];
          DLT_ADR_LOWER_ONE: rdata_ff <= lower_bound_pair_one_ff[31:0];
          DLT_ADR_UPPER_TWO: rdata_ff <= upper_bound_pair_two_ff[31:0];
          DLT_ADR_LOWER_TWO: rdata_ff <= lower_bound_pair_two_ff[31:0];
          DLT_ADR_UPPER_HI: rdata_ff <= {20'h0_0000, upper_hi_ff};
          DLT_ADR_CTRL: rdata_ff <= {24'h00_0000, ctrl_ff};
          DLT_ADR_RESULT: rdata_ff <= {26'h000_0000, hit_two_ff, hit_one_ff,
                                       fail_two_ff, fail_one_ff};
          DLT_ADR_PULSE: rdata_ff <= pulse_ff[31:0];
          DLT_ADR_IRQ_STAT: rdata_ff <= {30'h0000_0000, irq_stat_ff};
          DLT_ADR_IRQ_MASK: rdata_ff <= {30'h0000_0000, irq_mask_ff};
          DLT_ADR_INDIC: rdata_ff <= {27'h000_0000, indic};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // dlt_top

//--- src/dlt_pkg.sv
package dlt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  // Bounds span -4294967295..+4294967295: 33-bit two's complement
  localparam int DLT_VAL_W = 33;
  // Longest pulse, 99999.999 s in cycles, needs 44 bits
  localparam int DLT_PULSE_W = 44;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] DLT_ADR_UPPER_ONE = 8'h00;
  localparam logic [7:0] DLT_ADR_LOWER_ONE = 8'h04;
  localparam logic [7:0] DLT_ADR_UPPER_TWO = 8'h08;
  localparam logic [7:0] DLT_ADR_LOWER_TWO = 8'h0c;
  localparam logic [7:0] DLT_ADR_UPPER_HI = 8'h10;
  localparam logic [7:0] DLT_ADR_CTRL = 8'h14;
  localparam logic [7:0] DLT_ADR_CMD = 8'h18;
  localparam logic [7:0] DLT_ADR_RESULT = 8'h1c;
  localparam logic [7:0] DLT_ADR_PULSE = 8'h20;
  localparam logic [7:0] DLT_ADR_IRQ_STAT = 8'h24;
  localparam logic [7:0] DLT_ADR_IRQ_MASK = 8'h28;
  localparam logic [7:0] DLT_ADR_INDIC = 8'h2c;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int DLT_CTRL_EN_ONE = 0;
  localparam int DLT_CTRL_EN_TWO = 1;
  localparam int DLT_CTRL_AUTO_ONE = 2;
  localparam int DLT_CTRL_AUTO_TWO = 3;
  localparam int DLT_CTRL_SENSE_LOW = 4;
  localparam int DLT_CTRL_OUT_EN = 5;
  localparam int DLT_CTRL_PULSE_EN = 6;
  localparam int DLT_CTRL_LATCH = 7;
  localparam logic [7:0] DLT_CTRL_RST = 8'h0c;

  // Command register fields (write-only pulses)
  localparam int DLT_CMD_CLR_ONE = 0;
  localparam int DLT_CMD_CLR_TWO = 1;
  localparam int DLT_CMD_CLR_MASTER = 2;

  // Interrupt bits
  localparam int DLT_IRQ_FAIL_ONE = 0;
  localparam int DLT_IRQ_FAIL_TWO = 1;
  localparam int DLT_IRQ_W = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int DLT_CLK_MHZ = 100;
  localparam int DLT_PULSE_RST_MS = 2;
  localparam longint DLT_CYC_PER_MS = longint'(DLT_CLK_MHZ) * 1000;
  localparam logic [DLT_PULSE_W-1:0] DLT_PULSE_RST =
    DLT_PULSE_W'(longint'(DLT_PULSE_RST_MS) * DLT_CYC_PER_MS);
  localparam logic [DLT_PULSE_W-1:0] DLT_PULSE_MIN = DLT_PULSE_W'(DLT_CYC_PER_MS);
  localparam logic [DLT_PULSE_W-1:0] DLT_PULSE_MAX =
    DLT_PULSE_W'(longint'(99999999) * DLT_CYC_PER_MS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic high;
    logic low;
  } dlt_hit_t;

  typedef struct packed {
    logic ind_high;
    logic ind_in;
    logic ind_low;
    logic inside_window_two_msg;
    logic digit_two;
  } dlt_indic_t;

  typedef enum logic [1:0] {
    DLT_PS_IDLE = 2'b00,
    DLT_PS_HOLD = 2'b01,
    DLT_PS_DONE = 2'b10
  } dlt_pstate_t;

endpackage

//--- src/dlt_pulse.sv
`timescale 1ns/1ps
module dlt_pulse
  import dlt_pkg::*;
#(
  parameter int W = DLT_PULSE_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic pulse_en,
  input wire logic [W-1:0] width,
  input wire logic level,
  // Output
  output logic active
);

  dlt_pstate_t st_ff;
  logic [W-1:0] cnt_ff;

  // ****************************************************************
  // Level passes straight through; pulse mode fires once per rise
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= DLT_PS_IDLE;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      unique case (st_ff)
        DLT_PS_IDLE:
        begin
          if (pulse_en && level)
          begin
            st_ff <= DLT_PS_HOLD;
            cnt_ff <= width;
          end
        end
        DLT_PS_HOLD:
        begin
          if (cnt_ff <= W'(1))
            st_ff <= DLT_PS_DONE;
          cnt_ff <= cnt_ff - W'(1);
        end
        DLT_PS_DONE:
        begin
          if (!level)
            st_ff <= DLT_PS_IDLE;
        end
        default:
          st_ff <= DLT_PS_IDLE;
      endcase
    end
  end

  assign active = pulse_en ? (st_ff == DLT_PS_HOLD) : level;

endmodule // dlt_pulse

//--- bench/dlt_top_properties.sv
`timescale 1ns/1ps
module dlt_props
  import dlt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register writes
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Measurement and outputs
  input wire logic reading_valid,
  input wire logic local_limits_off,
  input wire dlt_indic_t indic,
  input wire dlt_hit_t event_one,
  input wire dlt_hit_t event_two,
  input wire logic [4:0] dig_out,
  input wire logic irq
);
  // ********
  // Control mirror
  // ********
  logic [7:0] ctrl_ff;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_ff <= DLT_CTRL_RST;
    else if (reg_wr && reg_addr == DLT_ADR_CTRL)
      ctrl_ff <= reg_wdata[7:0];
  end
  // Local disable as the design sees it, two stages late
  logic loc1_ff, loc2_ff;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loc1_ff <= 1'b0;
      loc2_ff <= 1'b0;
    end
    else
    begin
      loc1_ff <= local_limits_off;
      loc2_ff <= loc1_ff;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ********
  // Properties
  // ********
  property p_ind_one;
    ctrl_ff[DLT_CTRL_EN_ONE] && !loc2_ff |=> indic.ind_high == $past(event_one.high) &&
      indic.ind_low == $past(event_one.low) && !indic.digit_two;
  endproperty
  a_ind_one: assert property (p_ind_one) else $error("pair one indicators wrong");
  property p_ind_two;
    ctrl_ff[1:0] == 2'b10 && !loc2_ff |=> indic.ind_high == $past(event_two.high) &&
      indic.digit_two == ($past(event_two.high) || $past(event_two.low));
  endproperty
  a_ind_two: assert property (p_ind_two) else $error("pair two indicators wrong");
  property p_out_map;
    ctrl_ff[DLT_CTRL_OUT_EN] && !ctrl_ff[DLT_CTRL_PULSE_EN] |=>
      (dig_out[3:0] ^ {4{$past(ctrl_ff[DLT_CTRL_SENSE_LOW])}}) ==
      $past({event_two.high, event_two.low, event_one.high, event_one.low});
  endproperty
  a_out_map: assert property (p_out_map) else $error("output map wrong");
  property p_out_off;
    !ctrl_ff[DLT_CTRL_OUT_EN] |=> dig_out == {5{$past(ctrl_ff[DLT_CTRL_SENSE_LOW])}};
  endproperty
  a_out_off: assert property (p_out_off) else $error("output active while off");
  property p_one_off;
    reading_valid && !ctrl_ff[DLT_CTRL_EN_ONE] |=> event_one == 2'b00;
  endproperty
  a_one_off: assert property (p_one_off) else $error("disabled pair one hit");
  property p_two_off;
    reading_valid && !ctrl_ff[DLT_CTRL_EN_TWO] |=> event_two == 2'b00;
  endproperty
  a_two_off: assert property (p_two_off) else $error("disabled pair two hit");
  property p_local_off;
    local_limits_off [*3] ##0 reading_valid |=> event_one == 2'b00 && event_two == 2'b00;
  endproperty
  a_local_off: assert property (p_local_off) else $error("hit while local off");
  property p_irq_rise;
    $rose(irq) |-> $past(reading_valid) || $past(reg_wr);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
endmodule // dlt_props

//--- bench/dlt_handler.sv
`timescale 1ns/1ps
module dlt_handler
(
  // Handler lines
  input wire logic [4:0] dig_out,
  input wire logic sense_low,
  // Bin choice
  output logic [1:0] bin
);
  logic [4:0] act;
  // Lines three and four mean outside window two
  assign act = dig_out ^ {5{sense_low}};
  assign bin = (act[2] || act[3]) ? 2'h3 : (act[4] ? 2'h2 : 2'h1);
endmodule // dlt_handler

//--- bench/test_dual_limit_test_outputs.sv
`timescale 1ns/1ps
module test_dual_limit_test_outputs
  import dlt_pkg::*;
();
  localparam int PR = 10;
  localparam logic signed [32:0] U1 = 100, L1 = -100, U2 = 200, L2 = -200;
  logic core_clk, rstn, reg_wr, reg_rd, reading_valid, instr_idle, local_limits_off;
  logic irq, sense_low, rd_seen;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, n;
  logic [32:0] reading;
  logic [4:0] dig_out;
  logic [1:0] bin;
  logic [3:0] h;
  logic signed [32:0] r;
  logic signed [32:0] tbl [8] = '{0, 100, -100, 99, 200, -201, 33'sd4294967295,
    -33'sd4294967295};
  logic [31:0] expq [$];
  int bad_count, checked;
  dlt_indic_t indic;
  dlt_hit_t event_one, event_two;
  dlt_top #(.PULSE_RST(DLT_PULSE_W'(PR))) dut_u (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reading(reading), .reading_valid(reading_valid),
    .instr_idle(instr_idle), .local_limits_off(local_limits_off), .indic(indic),
    .event_one(event_one), .event_two(event_two), .dig_out(dig_out), .irq(irq));
  dlt_handler hnd_u (.dig_out(dig_out), .sense_low(sense_low), .bin(bin));
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] hits(logic signed [32:0] v);
    return {v >= U2, v <= L2, v >= U1, v <= L1};
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic bnd(logic [7:0] a, logic [32:0] v);
    wr(DLT_ADR_UPPER_HI, {31'h0, v[32]});
    wr(a, v[31:0]);
  endtask
  // Outputs are sampled three edges after the reading is taken
  task automatic meas(logic [32:0] v);
    reading <= v;
    reading_valid <= 1'b1;
    @(posedge core_clk);
    reading_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    if (rd_seen)
      check("reg_rdata", reg_rdata, expq.pop_front());
    rd_seen <= reg_rd;
  end
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    bad_count++;
    results();
  end
  // ********
  // Scenarios
  // ********
  initial
  begin
    {rstn, reg_wr, reg_rd, reading_valid, instr_idle, local_limits_off} = 6'h0;
    {sense_low, reg_addr, reg_wdata, reading} = '0;
    seed = 32'h06e5c633;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(DLT_ADR_CTRL, 32'h0000000c);
    rd(DLT_ADR_PULSE, PR);
    rd(8'h30, 32'h0);
    bnd(DLT_ADR_UPPER_ONE, U1);
    bnd(DLT_ADR_LOWER_ONE, L1);
    bnd(DLT_ADR_UPPER_TWO, U2);
    bnd(DLT_ADR_LOWER_TWO, L2);
    for (int s = 0; s < 2; s++)
    begin
      sense_low <= s[0];
      wr(DLT_ADR_CTRL, {26'h0, 1'b1, s[0], 4'h3});
      for (int i = 0; i < 8; i++)
      begin
        r = (i == 0) ? $signed(33'(rnd() % 32'd199)) - 33'sd99 : tbl[i];
        h = hits(r);
        wr(DLT_ADR_CMD, 32'h3);
        meas(r);
        check("dig_out", 32'(dig_out), {27'h0, {5{sense_low}} ^ {|h, h}});
        check("bin", 32'(bin), (h[3] | h[2]) ? 32'h3 : (|h ? 32'h2 : 32'h1));
        check("indic", 32'(indic), {27'h0, h[1], !(h[1] | h[0]), h[0], 2'b00});
        rd(DLT_ADR_RESULT, {26'h0, h, |h[3:2], |h[1:0]});
      end
    end
    sense_low <= 1'b0;
    wr(DLT_ADR_IRQ_STAT, 32'h3);
    wr(DLT_ADR_IRQ_MASK, 32'h1);
    wr(DLT_ADR_CTRL, 32'h03);
    check("irq", 32'(irq), 32'h0);
    meas(33'sd150);
    check("dig_out", 32'(dig_out), 32'h0);
    check("irq", 32'(irq), 32'h1);
    wr(DLT_ADR_IRQ_MASK, 32'h2);
    check("irq", 32'(irq), 32'h0);
    wr(DLT_ADR_IRQ_MASK, 32'h1);
    wr(DLT_ADR_IRQ_STAT, 32'h1);
    check("irq", 32'(irq), 32'h0);
    bnd(DLT_ADR_LOWER_TWO, -33'sd4294967295);
    wr(DLT_ADR_CTRL, 32'h02);
    meas(-33'sd4294967294);
    check("indic", 32'(indic) & 32'h17, 32'h02);
    wr(DLT_ADR_CMD, 32'h3);
    meas(33'sd300);
    check("indic", 32'(indic) & 32'h17, 32'h11);
    rd(DLT_ADR_RESULT, 32'h22);
    meas(-33'sd4294967295);
    rd(DLT_ADR_RESULT, 32'h12);
    local_limits_off <= 1'b1;
    wr(DLT_ADR_CMD, 32'h3);
    meas(33'sd300);
    rd(DLT_ADR_RESULT, 32'h0);
    local_limits_off <= 1'b0;
    for (int a = 0; a < 2; a++)
    begin
      instr_idle <= 1'b0;
      wr(DLT_ADR_CTRL, a ? 32'h01 : 32'h05);
      meas(33'sd150);
      rd(DLT_ADR_RESULT, 32'h09);
      instr_idle <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(DLT_ADR_RESULT, a ? 32'h09 : 32'h08);
      wr(DLT_ADR_CMD, 32'h1);
      rd(DLT_ADR_RESULT, 32'h08);
    end
    instr_idle <= 1'b0;
    wr(DLT_ADR_CTRL, 32'ha1);
    meas(33'sd150);
    meas(33'sd0);
    check("dig_out", 32'(dig_out), 32'h10);
    wr(DLT_ADR_CMD, 32'h4);
    @(posedge core_clk);
    check("dig_out", 32'(dig_out), 32'h0);
    wr(DLT_ADR_CTRL, 32'h61);
    meas(33'sd150);
    n = 0;
    repeat (30)
    begin
      if (dig_out[1] === 1'b1)
        n++;
      @(posedge core_clk);
    end
    check("pulse", n, PR);
    results();
  end
endmodule // test_dual_limit_test_outputs

bind dlt_top dlt_props chk_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reading_valid(reading_valid),
  .local_limits_off(local_limits_off), .indic(indic), .event_one(event_one),
  .event_two(event_two), .dig_out(dig_out), .irq(irq));
